// *** rtl/vacc_clutch.sv ***
`timescale 1ns/10ps
`include "vacc_cfg.svh"
// Notes on behaviour
// - engaged clutch passes all input travel; disengaged passes none
// - time-constant smoothing uses fixed constant, slip follows speed
// - time-constant smoothing restarts when input travel changes after completion
// - slippage systems keep set slippage regardless of drive speed
// - slippage systems pass later travel changes directly after completion
// - linear system ramps output speed, accumulated slip equals set slippage
// - complete flag clears at each start, sets when remainder below in-position range
// - mode value above 4 flags error, previous mode kept
// - mode changes accepted at any time
// - on/off mode: engaged while command on, disengaged while off
// - on/off mode follows command within one operation cycle
// - status flag shows clutch state, refreshed each operation cycle
// - address mode engages when command on and position reaches engage address
// - address mode disengages when command off and position reaches disengage address
// - address mode ignores engage address while off, disengage address while on
// - compare uses axis position, or in-revolution position when selected
// - addresses take effect immediately; written as signed 32-bit values
// - address mode 2 alternates engage and disengage while command on
// - address mode 2: command off disengages, command on resumes alternation
// - external input only with incremental encoder; needs command and start input
module vacc_clutch #(
    parameter int OP_CYCLES = `VACC_OP_CYCLES,
    parameter int EXP_SHIFT = `VACC_EXP_SHIFT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // drive module side
    input vacc_pkg::vacc_drive_t drive_in,
    input wire logic drive_is_encoder,
    input wire logic encoder_start_input,
    // output axis side
    output vacc_pkg::vacc_axis_t axis_out,
    output logic clutch_on,
    output logic smooth_done
);
    import vacc_pkg::*;

    // --------------------------------------------------
    // helpers
    // --------------------------------------------------
    // true when the path prev -> cur touches or crosses addr
    function automatic logic reached(input logic signed [31:0] prev, input logic signed [31:0] cur,
                                     input logic signed [31:0] addr);
        reached = (cur == addr) || ((prev < addr) && (cur > addr)) || ((prev > addr) && (cur < addr));
    endfunction

    function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
        umin = (a < b) ? a : b;
    endfunction

    // --------------------------------------------------
    // registers
    // --------------------------------------------------
    logic [31:0] ctrl_q;
    vacc_mode_t mode_q;
    logic mode_err_q;
    logic signed [31:0] on_addr_q;
    logic signed [31:0] off_addr_q;
    logic [31:0] slip_q;
    logic [31:0] inpos_q;
    logic [3:0] tconst_q;
    logic [31:0] ramp_q;

    logic [31:0] tick_cnt_q;
    logic tick;
    logic on_q;
    logic done_q;
    logic [31:0] rem_q;
    logic [31:0] lin_q;
    logic signed [31:0] tc_out_q;
    logic signed [31:0] prev_pos_q;
    vacc_axis_t axis_q;
    logic [31:0] rdata_q;

    // --------------------------------------------------
    // register decode
    // --------------------------------------------------
    wire cmd = ctrl_q[`VACC_CTRL_CMD];
    wire vacc_sys_t sys = vacc_sys_t'(ctrl_q[`VACC_CTRL_SYS_HI:`VACC_CTRL_SYS_LO]);
    wire use_rev = ctrl_q[`VACC_CTRL_REV];
    wire ext_active = ctrl_q[`VACC_CTRL_EXT] & drive_is_encoder;
    wire cmd_eff = cmd & (~ext_active | encoder_start_input);

    wire wr_ctrl = reg_wr && (reg_addr == `VACC_OFF_CTRL);
    wire wr_mode = reg_wr && (reg_addr == `VACC_OFF_MODE);
    wire wr_on_addr = reg_wr && (reg_addr == `VACC_OFF_ON_ADDR);
    wire wr_off_addr = reg_wr && (reg_addr == `VACC_OFF_OFF_ADDR);
    wire wr_slip = reg_wr && (reg_addr == `VACC_OFF_SLIP);
    wire wr_inpos = reg_wr && (reg_addr == `VACC_OFF_INPOS);
    wire wr_tconst = reg_wr && (reg_addr == `VACC_OFF_TCONST);
    wire wr_ramp = reg_wr && (reg_addr == `VACC_OFF_RAMP);
    wire mode_ok = (reg_wdata[31:3] == 29'h0) && (reg_wdata[2:0] <= `VACC_MODE_MAX);

    // --------------------------------------------------
    // operation cycle timer
    // --------------------------------------------------
    assign tick = (tick_cnt_q == 32'(OP_CYCLES - 1));

    always_ff @(posedge mclk)
    begin
        if (rst || tick)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // --------------------------------------------------
    // engage decision
    // --------------------------------------------------
    // compare source
    wire signed [31:0] cmp_pos = use_rev ? drive_in.rev_pos : drive_in.axis_pos;
    wire reach_on = reached(prev_pos_q, cmp_pos, on_addr_q);
    wire reach_off = reached(prev_pos_q, cmp_pos, off_addr_q);
    logic tgt;

    always_comb
    begin
        tgt = on_q;
        case (mode_q)
            VACC_ONOFF: tgt = cmd_eff;
            VACC_ADDR:
            begin
                if (cmd_eff && reach_on)
                    tgt = 1'b1;
                else if (!cmd_eff && reach_off)
                    tgt = 1'b0;
            end
            VACC_ADDR2:
            begin
                if (!cmd_eff)
                    tgt = 1'b0;
                else if (!on_q && reach_on)
                    tgt = 1'b1;
                else if (on_q && reach_off)
                    tgt = 1'b0;
            end
            // one-shot behaviour not carried: clutch held off
            default: tgt = 1'b0;
        endcase
    end

    // --------------------------------------------------
    // slippage smoothing
    // --------------------------------------------------
    wire start = tgt != on_q;
    wire signed [31:0] d = drive_in.travel;
    wire neg = d[31];
    wire [31:0] mag = neg ? 32'(-d) : 32'(d);
    // each engage or disengage reloads the full slippage
    wire [31:0] rem_now = start ? slip_q : rem_q;
    wire [31:0] lin_now = start ? mag : lin_q;
    // slip measured in travel, so speed does not change the total
    wire [31:0] piece_exp = umin(umin(mag, (rem_now >> EXP_SHIFT) + 32'h1), rem_now);
    // deficit steps down linearly, clamped so the sum is the slippage
    wire [31:0] piece_lin = umin(umin(mag, lin_now), rem_now);
    wire [31:0] piece = (sys == VACC_LINEAR) ? piece_lin : piece_exp;
    wire [31:0] rem_d = rem_now - piece;
    wire [31:0] lin_step = (lin_now > ramp_q) ? lin_now - ramp_q : 32'h1;
    wire [31:0] lin_d = (lin_now == 32'h0) ? 32'h1 : lin_step;
    // piece is zero once remainder is spent, travel passes directly
    wire [31:0] slip_mag = tgt ? mag - piece : piece;
    wire signed [31:0] slip_out = neg ? -$signed(slip_mag) : $signed(slip_mag);
    // complete once remainder below in-position range
    wire slip_done = !start && (rem_q < inpos_q);

    // --------------------------------------------------
    // time constant smoothing
    // --------------------------------------------------
    // target travel is all input when engaged, none when not
    wire signed [31:0] direct_out = tgt ? d : 32'sh0;
    wire signed [31:0] tc_diff = direct_out - tc_out_q;
    wire signed [31:0] tc_shr = tc_diff >>> tconst_q;
    wire signed [31:0] tc_step = (tc_shr == 32'sh0) ? tc_diff : tc_shr;
    wire signed [31:0] tc_d = tc_out_q + tc_step;
    // any later change of input while engaged reopens smoothing
    wire tc_done = !start && (tc_diff == 32'sh0);

    // --------------------------------------------------
    // output select
    // --------------------------------------------------
    logic signed [31:0] out_travel;
    logic done_d;

    always_comb
    begin
        out_travel = direct_out;
        done_d = 1'b1;
        case (sys)
            VACC_TCONST:
            begin
                out_travel = tc_d;
                done_d = tc_done;
            end
            VACC_EXP, VACC_LINEAR:
            begin
                out_travel = slip_out;
                done_d = slip_done;
            end
            default:
            begin
                out_travel = direct_out;
                done_d = 1'b1;
            end
        endcase
    end

    // --------------------------------------------------
    // operation cycle state
    // --------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            on_q <= 1'b0;
            done_q <= 1'b1;
            rem_q <= 32'h0;
            lin_q <= 32'h0;
            tc_out_q <= 32'sh0;
            prev_pos_q <= 32'sh0;
        end
        else
        begin
            if (tick)
            begin
                // state and flag refreshed once per operation cycle
                on_q <= tgt;
                done_q <= done_d;
                rem_q <= rem_d;
                lin_q <= lin_d;
                tc_out_q <= tc_d;
                prev_pos_q <= cmp_pos;
            end
        end
    end

    // --------------------------------------------------
    // output axis
    // --------------------------------------------------
    // travel holds between pulses, so the axis may take it late
    always_ff @(posedge mclk)
    begin
        if (rst)
            axis_q <= '0;
        else
        begin
            axis_q.valid <= tick;
            if (tick)
                axis_q.travel <= out_travel;
        end
    end

    // --------------------------------------------------
    // register writes
    // --------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_q <= `VACC_RST_CTRL;
            mode_q <= vacc_mode_t'(`VACC_RST_MODE);
            mode_err_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata;
            // mode taken at any time; bad value keeps old mode
            if (wr_mode && mode_ok)
            begin
                mode_q <= vacc_mode_t'(reg_wdata[2:0]);
                mode_err_q <= 1'b0;
            end
            else if (wr_mode)
                mode_err_q <= 1'b1;
        end
    end

    // addresses used from the clock after the write, so the next tick already judges them
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            on_addr_q <= 32'sh0;
            off_addr_q <= 32'sh0;
        end
        else
        begin
            if (wr_on_addr)
                on_addr_q <= reg_wdata;
            if (wr_off_addr)
                off_addr_q <= reg_wdata;
        end
    end

    // --------------------------------------------------
    // smoothing settings
    // --------------------------------------------------
    // taken as written: in the linear system a slippage below the travel per cycle is spent in one cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            slip_q <= `VACC_RST_SLIP;
            inpos_q <= `VACC_RST_INPOS;
            tconst_q <= `VACC_RST_TCONST;
            ramp_q <= `VACC_RST_RAMP;
        end
        else
        begin
            if (wr_slip)
                slip_q <= reg_wdata;
            if (wr_inpos)
                inpos_q <= reg_wdata;
            if (wr_tconst)
                tconst_q <= reg_wdata[3:0];
            if (wr_ramp)
                ramp_q <= reg_wdata;
        end
    end

    // --------------------------------------------------
    // register reads
    // --------------------------------------------------
    wire [31:0] status_w = {25'h0, mode_q, ext_active, mode_err_q, done_q, on_q};
    logic [31:0] rd_mux;

    always_comb
    begin
        if (reg_addr == `VACC_OFF_CTRL)
            rd_mux = ctrl_q;
        else if (reg_addr == `VACC_OFF_MODE)
            rd_mux = {29'h0, mode_q};
        else if (reg_addr == `VACC_OFF_ON_ADDR)
            rd_mux = on_addr_q;
        else if (reg_addr == `VACC_OFF_OFF_ADDR)
            rd_mux = off_addr_q;
        else if (reg_addr == `VACC_OFF_SLIP)
            rd_mux = slip_q;
        else if (reg_addr == `VACC_OFF_INPOS)
            rd_mux = inpos_q;
        else if (reg_addr == `VACC_OFF_TCONST)
            rd_mux = {28'h0, tconst_q};
        else if (reg_addr == `VACC_OFF_RAMP)
            rd_mux = ramp_q;
        else if (reg_addr == `VACC_OFF_STATUS)
            rd_mux = status_w;
        else
            rd_mux = 32'h0;
    end

    // read data only valid the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (rst || !reg_rd)
            rdata_q <= 32'h0;
        else
            rdata_q <= rd_mux;
    end

    assign reg_rdata = rdata_q;
    assign axis_out = axis_q;
    assign clutch_on = on_q;
    assign smooth_done = done_q;
endmodule

// *** common/vacc_cfg.svh ***
`ifndef VACC_CFG_SVH
`define VACC_CFG_SVH

// --------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------
`define VACC_OFF_CTRL 8'h00
`define VACC_OFF_MODE 8'h04
`define VACC_OFF_ON_ADDR 8'h08
`define VACC_OFF_OFF_ADDR 8'h0c
`define VACC_OFF_SLIP 8'h10
`define VACC_OFF_INPOS 8'h14
`define VACC_OFF_TCONST 8'h18
`define VACC_OFF_RAMP 8'h1c
`define VACC_OFF_STATUS 8'h20

// --------------------------------------------------
// control fields
// --------------------------------------------------
`define VACC_CTRL_CMD 0
`define VACC_CTRL_SYS_LO 1
`define VACC_CTRL_SYS_HI 2
`define VACC_CTRL_EXT 3
`define VACC_CTRL_REV 4

// --------------------------------------------------
// status fields
// --------------------------------------------------
`define VACC_STAT_ON 0
`define VACC_STAT_DONE 1
`define VACC_STAT_MERR 2
`define VACC_STAT_EXT 3
`define VACC_STAT_MODE_LO 4
`define VACC_STAT_MODE_HI 6

// --------------------------------------------------
// reset values and limits
// --------------------------------------------------
`define VACC_RST_CTRL 32'h0000_0000
`define VACC_RST_MODE 3'h0
`define VACC_RST_SLIP 32'h0000_0400
`define VACC_RST_INPOS 32'h0000_0001
`define VACC_RST_TCONST 4'h3
`define VACC_RST_RAMP 32'h0000_0001
`define VACC_MODE_MAX 3'h4
`define VACC_EXP_SHIFT 3

// --------------------------------------------------
// timing
// --------------------------------------------------
`define VACC_CLK_NS 10
`define VACC_OP_CYCLE_US 1000
`define VACC_OP_CYCLES ((`VACC_OP_CYCLE_US * 1000) / `VACC_CLK_NS)

`endif

// *** common/vacc_pkg.sv ***
package vacc_pkg;

    // clutch operating mode as written by software
    typedef enum logic [2:0] {
        VACC_ONOFF,
        VACC_ADDR,
        VACC_ADDR2,
        VACC_SHOT_ON,
        VACC_SHOT_OFF
    } vacc_mode_t;

    // smoothing system
    typedef enum logic [1:0] {
        VACC_DIRECT,
        VACC_TCONST,
        VACC_EXP,
        VACC_LINEAR
    } vacc_sys_t;

    // one operation cycle of the drive module side
    typedef struct packed {
        logic signed [31:0] travel;
        logic signed [31:0] axis_pos;
        logic signed [31:0] rev_pos;
    } vacc_drive_t;

    // one operation cycle towards the output axis
    typedef struct packed {
        logic valid;
        logic signed [31:0] travel;
    } vacc_axis_t;

endpackage

// *** verification/vacc_clutch_properties.sv ***
`timescale 1ns/10ps
module vacc_clutch_check #(
    parameter int OP_CYCLES = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // drive and axis sides
    input vacc_pkg::vacc_drive_t drive_in,
    input wire logic drive_is_encoder,
    input wire logic encoder_start_input,
    input vacc_pkg::vacc_axis_t axis_out,
    input wire logic clutch_on,
    input wire logic smooth_done
);
    import vacc_pkg::*;
    logic [4:0] ctrl_q;
    logic [2:0] mode_q;
    logic err_q;
    logic seen_q;
    int gap_q;
    wire mode_ok = reg_wdata <= 32'h4;
    wire mode_wr = reg_wr && reg_addr == 8'h04;
    wire cmd_eff = ctrl_q[0] && (!ctrl_q[3] || !drive_is_encoder || encoder_start_input);
    wire slip_sys = ctrl_q[2];
    wire direct_sys = ctrl_q[2:1] == 2'h0;

    // shadow of the software settings, so mode, error and control expectations never come from the design
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_q <= 5'h0;
            mode_q <= 3'h0;
            err_q <= 1'b0;
            seen_q <= 1'b0;
            gap_q <= 0;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h00)
            begin
                ctrl_q <= reg_wdata[4:0];
            end
            if (mode_wr)
            begin
                mode_q <= mode_ok ? reg_wdata[2:0] : mode_q;
                err_q <= !mode_ok;
            end
            seen_q <= seen_q || axis_out.valid;
            gap_q <= axis_out.valid ? 0 : gap_q + 1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_status_rd;
        reg_rd && reg_addr == 8'h20;
    endsequence

    a_tick_period: assert property (
        seen_q |-> (axis_out.valid ? gap_q == OP_CYCLES - 1 : gap_q < OP_CYCLES - 1))
        else $error("output pulse spacing differs from the op cycle");
    a_state_held: assert property (
        !axis_out.valid |-> $stable(clutch_on))
        else $error("clutch state moved between op cycles");
    a_done_held: assert property (
        !axis_out.valid |-> $stable(smooth_done))
        else $error("complete flag moved between op cycles");
    a_direct_pass: assert property (
        axis_out.valid && $past(direct_sys) |->
        axis_out.travel == (clutch_on ? $past(drive_in.travel) : 32'sh0))
        else $error("direct clutch travel wrong");
    a_onoff_follow: assert property (
        axis_out.valid && $past(mode_q) == 3'h0 |-> clutch_on == $past(cmd_eff))
        else $error("on/off mode state does not follow command");
    a_status_read: assert property (
        s_status_rd |=> reg_rdata[6:4] == $past(mode_q) && reg_rdata[2] == $past(err_q)
        && reg_rdata[0] == $past(clutch_on))
        else $error("status read wrong");
    a_slip_start: assert property (
        axis_out.valid && $past(slip_sys) && $changed(clutch_on) |-> !smooth_done)
        else $error("complete flag not cleared at smoothing start");
    a_shot_hold: assert property (
        axis_out.valid && $past(mode_q) >= 3'h3 |-> !clutch_on)
        else $error("one-shot mode engaged");
endmodule

bind vacc_clutch vacc_clutch_check #(.OP_CYCLES(OP_CYCLES)) u_check (
    .mclk(mclk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .drive_in(drive_in),
    .drive_is_encoder(drive_is_encoder),
    .encoder_start_input(encoder_start_input),
    .axis_out(axis_out),
    .clutch_on(clutch_on),
    .smooth_done(smooth_done)
);

// *** verification/vacc_drive_model.sv ***
`timescale 1ns/10ps
module vacc_drive_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pacing
    input wire logic signed [31:0] speed,
    input vacc_pkg::vacc_axis_t axis_out,
    // drive module
    output vacc_pkg::vacc_drive_t drive_in
);
    import vacc_pkg::*;
    // moves right after the output pulse, so values are stable at the next sample
    always @(posedge mclk)
    begin
        if (rst)
        begin
            drive_in <= '0;
        end
        else if (axis_out.valid)
        begin
            drive_in.travel <= speed;
            drive_in.axis_pos <= drive_in.axis_pos + speed;
            drive_in.rev_pos <= (drive_in.axis_pos + speed) & 32'sh3f;
        end
    end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import vacc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic drive_is_encoder = 1'b0;
    logic encoder_start_input = 1'b0;
    logic signed [31:0] speed = 32'sh0;
    vacc_drive_t drive_in;
    vacc_axis_t axis_out;
    logic clutch_on;
    logic smooth_done;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    vacc_clutch #(.OP_CYCLES(8)) DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_in(drive_in),
        .drive_is_encoder(drive_is_encoder), .encoder_start_input(encoder_start_input),
        .axis_out(axis_out), .clutch_on(clutch_on), .smooth_done(smooth_done));
    vacc_drive_model u_drive (.mclk(mclk), .rst(rst), .speed(speed), .axis_out(axis_out), .drive_in(drive_in));

    always #5 mclk = ~mclk;

    task automatic conclude();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // a hung wait must not stall the run
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // returns just after the next output pulse
    task automatic tick();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (axis_out.valid !== 1'b1 && n < 20);
    endtask

    // returns once the design has judged position t
    task automatic wait_pos(input logic signed [31:0] t);
        int n;
        n = 0;
        while (drive_in.axis_pos < t && n < 100)
        begin
            tick();
            n++;
        end
    endtask

    task automatic do_reset(input logic signed [31:0] sp);
        @(posedge mclk);
        rst <= 1'b1;
        speed <= sp;
        drive_is_encoder <= 1'b0;
        encoder_start_input <= 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
    endtask

    task automatic s_regs();
        logic [7:0] a [5] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
        logic [31:0] e [5] = '{32'h400, 32'h1, 32'h3, 32'h1, 32'h2};
        logic [31:0] d;
        do_reset(32'sh0);
        foreach (a[i])
        begin
            rd(a[i], d);
            check(d, e[i]);
        end
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, d);
        check(d, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h04, 32'h7);
        rd(8'h20, d);
        check(d, 32'h16);
        wr(8'h20, 32'hffff_ffff);
        wr(8'h04, 32'h2);
        rd(8'h20, d);
        check(d, 32'h22);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h3);
        tick();
        tick();
        chk1(clutch_on, 1'b0);
        wr(8'h04, 32'h4);
        rd(8'h20, d);
        check(d, 32'h42);
        tick();
        chk1(clutch_on, 1'b0);
    endtask

    task automatic s_onoff();
        logic [31:0] d;
        do_reset(32'sh5);
        tick();
        wr(8'h00, 32'h1);
        tick();
        chk1(clutch_on, 1'b1);
        check(axis_out.travel, 32'h5);
        rd(8'h20, d);
        check(d, 32'h3);
        wr(8'h00, 32'h0);
        tick();
        chk1(clutch_on, 1'b0);
        check(axis_out.travel, 32'h0);
        @(posedge mclk);
        drive_is_encoder <= 1'b1;
        wr(8'h00, 32'h9);
        tick();
        chk1(clutch_on, 1'b0);
        @(posedge mclk);
        encoder_start_input <= 1'b1;
        tick();
        chk1(clutch_on, 1'b1);
    endtask

    task automatic s_addr();
        do_reset(32'sh5);
        wr(8'h08, 32'h28);
        wr(8'h0c, 32'h50);
        wr(8'h04, 32'h1);
        wait_pos(32'sh3c);
        chk1(clutch_on, 1'b0);
        wr(8'h08, 32'h64);
        wr(8'h0c, 32'h78);
        wr(8'h00, 32'h1);
        wait_pos(32'sh5f);
        chk1(clutch_on, 1'b0);
        wait_pos(32'sh64);
        chk1(clutch_on, 1'b1);
        wait_pos(32'sh82);
        chk1(clutch_on, 1'b1);
        wr(8'h0c, 32'h96);
        wr(8'h00, 32'h0);
        wait_pos(32'sh91);
        chk1(clutch_on, 1'b1);
        wait_pos(32'sh96);
        chk1(clutch_on, 1'b0);
        wr(8'h00, 32'h10);
        tick();
        wr(8'h08, 32'h2a);
        wr(8'h00, 32'h11);
        wait_pos(32'sha5);
        chk1(clutch_on, 1'b0);
        wait_pos(32'shaa);
        chk1(clutch_on, 1'b1);
    endtask

    task automatic s_addr2();
        do_reset(32'sh5);
        wr(8'h08, 32'h1e);
        wr(8'h0c, 32'h3c);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        wait_pos(32'sh19);
        chk1(clutch_on, 1'b0);
        wait_pos(32'sh1e);
        chk1(clutch_on, 1'b1);
        wait_pos(32'sh3c);
        chk1(clutch_on, 1'b0);
        wr(8'h08, 32'h5a);
        wait_pos(32'sh5a);
        chk1(clutch_on, 1'b1);
        wr(8'h00, 32'h0);
        tick();
        chk1(clutch_on, 1'b0);
        wr(8'h08, 32'h78);
        wait_pos(32'sh7d);
        chk1(clutch_on, 1'b0);
        wr(8'h08, 32'h8c);
        wr(8'h00, 32'h1);
        wait_pos(32'sh8c);
        chk1(clutch_on, 1'b1);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (smooth_done !== 1'b1 && n < 200)
        begin
            tick();
            n++;
        end
    endtask

    task automatic s_tconst();
        do_reset(32'sh10);
        tick();
        wr(8'h00, 32'h3);
        tick();
        chk1(smooth_done, 1'b0);
        wait_done();
        check(axis_out.travel, 32'h10);
        speed <= 32'sh30;
        tick();
        tick();
        chk1(smooth_done, 1'b0);
        wait_done();
        check(axis_out.travel, 32'h30);
    endtask

    // slippage kept above the travel per op cycle, as software should
    task automatic s_slip(input logic [1:0] sys, input logic signed [31:0] sp);
        logic signed [31:0] slip;
        int n;
        do_reset(sp);
        wr(8'h10, 32'h12c);
        tick();
        wr(8'h00, {27'h0, sys, 1'b1});
        tick();
        chk1(smooth_done, 1'b0);
        slip = sp - axis_out.travel;
        n = 0;
        while (smooth_done !== 1'b1 && n < 300)
        begin
            tick();
            slip += sp - axis_out.travel;
            n++;
        end
        check(slip, 32'h12c);
        speed <= sp + 32'sh10;
        tick();
        tick();
        check(axis_out.travel, sp + 32'sh10);
        chk1(smooth_done, 1'b1);
        wr(8'h00, {27'h0, sys, 1'b0});
        tick();
        chk1(smooth_done, 1'b0);
    endtask

    initial
    begin
        s_regs();
        s_onoff();
        s_addr();
        s_addr2();
        s_tconst();
        s_slip(2'h2, 32'sh20);
        s_slip(2'h2, 32'sh40);
        s_slip(2'h3, 32'sh20);
        s_slip(2'h3, 32'sh40);
        conclude();
    end
endmodule
